// >>> rtl/ir_dim_pkg.sv
// Purpose: constants and types for the infrared dimming and power controller
// Assumes: 250 MHz system clock, pulse-distance frames with 8-bit data codes
// Notes: timing figures are kept in microseconds, the stop delay in seconds, and converted to cycles here
package ir_dim_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // Leader: 9000 us mark, 4500 us space (data) or 2250 us space (repeat)
  localparam int unsigned LEAD_MARK_MIN_US = 8000;
  localparam int unsigned LEAD_SPACE_DATA_MIN_US = 3500;
  localparam int unsigned LEAD_SPACE_REP_MIN_US = 1800;
  localparam int unsigned LEAD_SPACE_REP_MAX_US = 2800;
  localparam int unsigned BIT_ONE_MIN_US = 1800;
  localparam int unsigned BIT_MAX_US = 2800;
  localparam int unsigned BIT_MIN_US = 900;
  localparam int unsigned IDLE_US = 20000;
  localparam int unsigned WAKE_US = 100000;
  localparam int unsigned STOP_S = 10;
  localparam int unsigned LEAD_MARK_MIN_CYC = LEAD_MARK_MIN_US * CLK_MHZ;
  localparam int unsigned LEAD_DATA_MIN_CYC = LEAD_SPACE_DATA_MIN_US * CLK_MHZ;
  localparam int unsigned LEAD_REP_MIN_CYC = LEAD_SPACE_REP_MIN_US * CLK_MHZ;
  localparam int unsigned LEAD_REP_MAX_CYC = LEAD_SPACE_REP_MAX_US * CLK_MHZ;
  localparam int unsigned BIT_ONE_MIN_CYC = BIT_ONE_MIN_US * CLK_MHZ;
  localparam int unsigned BIT_MAX_CYC = BIT_MAX_US * CLK_MHZ;
  localparam int unsigned BIT_MIN_CYC = BIT_MIN_US * CLK_MHZ;
  localparam int unsigned IDLE_CYC = IDLE_US * CLK_MHZ;
  localparam int unsigned WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam longint unsigned STOP_CYC = longint'(STOP_S) * 64'd250000000;
  localparam int unsigned FRAME_BITS = 32;
  localparam logic [15:0] CUSTOMER_CODE = 16'h1234;
  localparam logic [7:0] CMD_MAX = 8'h00;
  localparam logic [7:0] CMD_MID = 8'h01;
  localparam logic [7:0] CMD_OFF = 8'h02;
  localparam logic [7:0] CMD_UP = 8'h03;
  localparam logic [7:0] CMD_DOWN = 8'h04;
  localparam logic [7:0] LEVEL_MAX = 8'hFF;
  localparam logic [7:0] LEVEL_MID = 8'h80;
  localparam logic [7:0] LEVEL_MIN = 8'h00;
  localparam logic [7:0] LEVEL_STEP = 8'h10;
  localparam logic [7:0] CMD_RESET = 8'h02;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } led_target_t;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_HALT = 2'b01,
    PWR_STOP = 2'b10
  } pwr_state_t;
endpackage : ir_dim_pkg

// >>> rtl/ir_receive_driver.sv
// Purpose: recover data and repeat frames from the infrared input
// Assumes: ir_n already synchronised, low means carrier present
// Notes: leader timing on one counter, bit length capture on another
`timescale 1ns/1ps
module ir_receive_driver
  import ir_dim_pkg::*;
#(
  // Divides every frame timing; 1 keeps real time, larger values shorten frames
  parameter int unsigned TIME_DIV = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Synchronised receive level, low is carrier
  input wire logic ir_n,
  // Frame events
  output logic data_frame_event,
  output logic repeat_frame_event,
  output logic [7:0] data_code,
  output logic line_active
);
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_LEAD_MARK = 3'b001,
    RX_LEAD_SPACE = 3'b010,
    RX_BIT_MARK = 3'b011,
    RX_BIT_SPACE = 3'b100
  } rx_state_t;

  localparam int unsigned T_LEAD_MARK = LEAD_MARK_MIN_CYC / TIME_DIV;
  localparam int unsigned T_LEAD_DATA = LEAD_DATA_MIN_CYC / TIME_DIV;
  localparam int unsigned T_REP_MIN = LEAD_REP_MIN_CYC / TIME_DIV;
  localparam int unsigned T_REP_MAX = LEAD_REP_MAX_CYC / TIME_DIV;
  localparam int unsigned T_BIT_ONE = BIT_ONE_MIN_CYC / TIME_DIV;
  localparam int unsigned T_BIT_MAX = BIT_MAX_CYC / TIME_DIV;
  localparam int unsigned T_BIT_MIN = BIT_MIN_CYC / TIME_DIV;
  localparam int unsigned T_IDLE = IDLE_CYC / TIME_DIV;

  rx_state_t state;
  rx_state_t next_state;
  logic [23:0] leader_interval_timer;
  logic [23:0] bit_capture_timer;
  logic [31:0] shift;
  logic [5:0] nbits;
  logic ir_prev;
  logic [23:0] idle_cnt;

  wire carrier = ~ir_n;
  wire fall = ir_prev & ~ir_n;
  wire rise = ~ir_prev & ir_n;
  wire lead_ok = leader_interval_timer >= 24'(T_LEAD_MARK);
  wire space_data = leader_interval_timer >= 24'(T_LEAD_DATA);
  wire space_rep = leader_interval_timer >= 24'(T_REP_MIN)
    && leader_interval_timer <= 24'(T_REP_MAX);
  wire bit_valid = bit_capture_timer >= 24'(T_BIT_MIN)
    && bit_capture_timer <= 24'(T_BIT_MAX);
  wire bit_one = bit_capture_timer >= 24'(T_BIT_ONE);
  wire [31:0] full_word = {bit_one, shift[31:1]};
  // Frame sent LSB first: customer low, customer high, data, inverted data
  wire frame_ok = full_word[15:0] == CUSTOMER_CODE
    && full_word[23:16] == ~full_word[31:24];
  wire timeout = bit_capture_timer == 24'(T_BIT_MAX + 1);

  always_comb begin
    next_state = state;
    unique case (state)
      RX_IDLE: if (fall) next_state = RX_LEAD_MARK;
      RX_LEAD_MARK: if (rise) next_state = lead_ok ? RX_LEAD_SPACE : RX_IDLE;
      RX_LEAD_SPACE: begin
        if (fall && space_rep) next_state = RX_IDLE;
        else if (fall && space_data) next_state = RX_BIT_MARK;
        else if (fall) next_state = RX_IDLE;
      end
      RX_BIT_MARK: begin
        if (rise) next_state = RX_BIT_SPACE;
        else if (timeout) next_state = RX_IDLE;
      end
      RX_BIT_SPACE: begin
        if (fall && !bit_valid) next_state = RX_IDLE;
        else if (fall && nbits == 6'(FRAME_BITS - 1)) next_state = RX_IDLE;
        else if (fall) next_state = RX_BIT_MARK;
        else if (timeout) next_state = RX_IDLE;
      end
      default: next_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= RX_IDLE;
      ir_prev <= 1'b1;
      leader_interval_timer <= '0;
      bit_capture_timer <= '0;
      shift <= '0;
      nbits <= '0;
      data_frame_event <= 1'b0;
      repeat_frame_event <= 1'b0;
      data_code <= CMD_RESET;
      idle_cnt <= '0;
      line_active <= 1'b0;
    end else begin
      state <= next_state;
      ir_prev <= ir_n;
      data_frame_event <= 1'b0;
      repeat_frame_event <= 1'b0;
      leader_interval_timer <= (fall || rise) ? '0 : leader_interval_timer + 24'd1;
      // Bit length runs falling edge to falling edge
      if (fall || state == RX_IDLE) bit_capture_timer <= '0;
      else if (!timeout) bit_capture_timer <= bit_capture_timer + 24'd1;
      if (state == RX_LEAD_SPACE && fall) nbits <= '0;
      if (state == RX_LEAD_SPACE && fall && space_rep) repeat_frame_event <= 1'b1;
      if (state == RX_BIT_SPACE && fall && bit_valid) begin
        shift <= full_word;
        nbits <= nbits + 6'd1;
        if (nbits == 6'(FRAME_BITS - 1) && frame_ok) begin
          data_frame_event <= 1'b1;
          data_code <= full_word[23:16];
        end
      end
      // Line counts as active until a quiet gap passes
      if (carrier) idle_cnt <= '0;
      else if (idle_cnt != 24'(T_IDLE)) idle_cnt <= idle_cnt + 24'd1;
      line_active <= carrier || state != RX_IDLE || idle_cnt != 24'(T_IDLE);
    end
  end
endmodule : ir_receive_driver

// >>> rtl/ir_dimming_power_controller.sv
// Purpose: command task, LED targets and low-power sequencing
// Assumes: ir_rx_n and stop_wake_interrupt are asynchronous pins
// Notes: halt and stop are reported as levels for the power manager
`timescale 1ns/1ps
module ir_dimming_power_controller
  import ir_dim_pkg::*;
#(
  parameter bit STOP_ENABLE = 1'b0,
  // Frame timing divider, only for short simulation runs
  parameter int unsigned TIME_DIV = 1,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter longint unsigned STOP_CYCLES = STOP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Infrared pins
  input wire logic ir_rx_n,
  input wire logic stop_wake_interrupt,
  // Dimming targets
  output led_target_t led_target,
  // Power state
  output logic halt_mode,
  output logic stop_mode
);
  logic [1:0] ir_sync;
  logic [1:0] wake_sync;
  logic data_frame_event;
  logic repeat_frame_event;
  logic [7:0] data_code;
  logic line_active;
  logic [7:0] command;
  logic cmd_pending;
  logic cmd_is_repeat;
  logic [7:0] level;
  logic [7:0] next_level;
  pwr_state_t pwr;
  pwr_state_t next_pwr;
  logic [31:0] wake_cnt;
  logic [31:0] quiet_cnt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ir_sync <= 2'b11;
      wake_sync <= 2'b11;
    end else begin
      ir_sync <= {ir_sync[0], ir_rx_n};
      wake_sync <= {wake_sync[0], stop_wake_interrupt};
    end
  end

  ir_receive_driver #(
    .TIME_DIV(TIME_DIV)
  ) u_rx (
    .sys_clk(sys_clk),
    .rst(rst),
    .ir_n(ir_sync[1]),
    .data_frame_event(data_frame_event),
    .repeat_frame_event(repeat_frame_event),
    .data_code(data_code),
    .line_active(line_active)
  );

  function automatic logic [7:0] step_up(input logic [7:0] v);
    step_up = (v > LEVEL_MAX - LEVEL_STEP) ? LEVEL_MAX : v + LEVEL_STEP;
  endfunction : step_up

  function automatic logic [7:0] step_down(input logic [7:0] v);
    step_down = (v < LEVEL_MIN + LEVEL_STEP) ? LEVEL_MIN : v - LEVEL_STEP;
  endfunction : step_down

  wire rx_event = data_frame_event | repeat_frame_event;
  wire stepping = command == CMD_UP || command == CMD_DOWN;
  wire leds_off = level == LEVEL_MIN;
  wire stop_wake = ~wake_sync[1] | ~ir_sync[1];
  wire wake_tick = wake_cnt == WAKE_CYCLES - 1;
  wire quiet_done = 64'(quiet_cnt) >= STOP_CYCLES;

  // Command task: absolute codes act once, step codes also act on repeats
  always_comb begin
    next_level = level;
    if (cmd_pending) begin
      unique case (command)
        CMD_MAX: if (!cmd_is_repeat) next_level = LEVEL_MAX;
        CMD_MID: if (!cmd_is_repeat) next_level = LEVEL_MID;
        CMD_OFF: if (!cmd_is_repeat) next_level = LEVEL_MIN;
        CMD_UP: next_level = step_up(level);
        CMD_DOWN: next_level = step_down(level);
        default: next_level = level;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      command <= CMD_RESET;
      cmd_pending <= 1'b0;
      cmd_is_repeat <= 1'b0;
      level <= LEVEL_MIN;
    end else begin
      cmd_pending <= rx_event;
      cmd_is_repeat <= repeat_frame_event;
      if (data_frame_event) command <= data_code;
      else if (repeat_frame_event) command <= data_code;
      level <= next_level;
    end
  end

  // All three channels follow the one level
  assign led_target = '{red: level, green: level, blue: level};

  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      PWR_NORMAL: begin
        if (STOP_ENABLE && quiet_done && leds_off) next_pwr = PWR_STOP;
        else if (!line_active && !cmd_pending) next_pwr = PWR_HALT;
      end
      PWR_HALT: begin
        if (STOP_ENABLE && quiet_done && leds_off) next_pwr = PWR_STOP;
        else if (line_active || wake_tick) next_pwr = PWR_NORMAL;
      end
      PWR_STOP: if (stop_wake) next_pwr = PWR_NORMAL;
      default: next_pwr = PWR_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr <= PWR_NORMAL;
      wake_cnt <= '0;
      quiet_cnt <= '0;
    end else begin
      pwr <= next_pwr;
      wake_cnt <= (pwr != PWR_HALT || wake_tick) ? '0 : wake_cnt + 32'd1;
      if (rx_event || pwr == PWR_STOP) quiet_cnt <= '0;
      else if (!quiet_done) quiet_cnt <= quiet_cnt + 32'd1;
    end
  end

  assign halt_mode = pwr == PWR_HALT;
  assign stop_mode = pwr == PWR_STOP;

  AST_DATA_LATCH: assert property (@(posedge sys_clk) disable iff (rst)
    data_frame_event |=> command == $past(data_code))
    else $error("command not latched from data frame");
  AST_REPEAT_RELOAD: assert property (@(posedge sys_clk) disable iff (rst)
    repeat_frame_event |=> command == $past(command))
    else $error("repeat changed command code");
  AST_MAX: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_pending && !cmd_is_repeat && command == CMD_MAX |=> level == LEVEL_MAX)
    else $error("max code did not light fully");
  AST_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_pending && !cmd_is_repeat && command == CMD_OFF |=> level == LEVEL_MIN)
    else $error("off code did not turn off");
  AST_UP_REPEAT: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_pending && command == CMD_UP && level < LEVEL_MAX |=> level > $past(level))
    else $error("up step missing");
  AST_SAT: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_pending && command == CMD_DOWN && level == LEVEL_MIN |=> level == LEVEL_MIN)
    else $error("down step wrapped");
  AST_RGB: assert property (@(posedge sys_clk) disable iff (rst)
    led_target.red == led_target.green && led_target.green == led_target.blue)
    else $error("channels disagree");
  AST_HALT_EXIT: assert property (@(posedge sys_clk) disable iff (rst)
    halt_mode && line_active && !(STOP_ENABLE && quiet_done && leds_off) |=> !halt_mode)
    else $error("halt not left on reception");
  AST_NO_STOP: assert property (@(posedge sys_clk) disable iff (rst)
    !STOP_ENABLE |-> !stop_mode)
    else $error("stop entered while disabled");
  AST_STOP_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
    stop_mode && stop_wake |=> pwr == PWR_NORMAL)
    else $error("stop not woken");
  AST_STOP_ONLY_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(stop_mode) |-> $past(leds_off) && $past(quiet_done))
    else $error("stop entered too early");
endmodule : ir_dimming_power_controller

// >>> testbench/ir_transmitter_model.sv
// Purpose: remote transmitter model sending pulse-distance infrared frames
// Assumes: receiver line has a pull-up, so it idles high between frames
// Notes: every frame length is divided by TIME_DIV, so larger values cost fewer clock cycles per frame
`timescale 1ns/1ps
module ir_transmitter_model #(
  parameter int unsigned TIME_DIV = 1
) (
  // Infrared line, low is carrier
  output logic ir_n
);
  initial begin
    ir_n = 1'b1;
  end

  task automatic pulse(input int unsigned mark_us, input int unsigned space_us);
    ir_n = 1'b0;
    #(real'(mark_us) * 1000.0 / real'(TIME_DIV));
    ir_n = 1'b1;
    #(real'(space_us) * 1000.0 / real'(TIME_DIV));
  endtask : pulse

  // Leader, 32 bits LSB first, then a stop mark
  task automatic send_data(input logic [15:0] cust, input logic [7:0] code,
      input logic [7:0] inv);
    logic [31:0] word;
    word = {inv, code, cust};
    pulse(9000, 4500);
    for (int i = 0; i < 32; i++) begin
      pulse(560, word[i] ? 1690 : 560);
    end
    pulse(560, 5000);
  endtask : send_data

  // Short leader space marks a repeat
  task automatic send_repeat();
    pulse(9000, 2250);
    pulse(560, 5000);
  endtask : send_repeat
endmodule : ir_transmitter_model

// >>> testbench/tb.sv
// Purpose: self-checking bench for the infrared dimming controller
// Assumes: expectations queued by the driver, compared by an output monitor
// Notes: stop and wake counts shortened; frame timing divided by TIME_DIV, so runs short
`timescale 1ns/1ps
module tb;
  import ir_dim_pkg::*;
  logic sys_clk;
  logic rst;
  wire ir_line;
  led_target_t led_target;
  logic halt_mode;
  logic stop_mode;
  int bad_count;
  int checks_done;
  logic [7:0] level;
  logic [7:0] last_code;
  logic [23:0] last_led;
  logic [23:0] exp_q[$];

  // Frames shortened together on both sides to keep the run short
  localparam int unsigned TIME_DIV = 4000;

  ir_transmitter_model #(.TIME_DIV(TIME_DIV)) i_ir_transmitter_model (.ir_n(ir_line));

  // Wake pin wired to the infrared line, as the board does
  ir_dimming_power_controller #(
    .STOP_ENABLE(1'b1),
    .TIME_DIV(TIME_DIV),
    .WAKE_CYCLES(100),
    .STOP_CYCLES(2000)
  ) i_ir_dimming_power_controller (
    .sys_clk(sys_clk),
    .rst(rst),
    .ir_rx_n(ir_line),
    .stop_wake_interrupt(ir_line),
    .led_target(led_target),
    .halt_mode(halt_mode),
    .stop_mode(stop_mode)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // Monitor: any target change must match the oldest queued note
  always @(posedge sys_clk) begin
    #1;
    if (rst === 1'b0 && led_target !== last_led) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("Error at %0t: unexpected target %h", $time, led_target);
      end else begin
        check(led_target, exp_q.pop_front());
      end
      last_led = led_target;
    end
  end

  task automatic expect_code(input logic [7:0] code, input bit rep);
    logic [7:0] nxt;
    nxt = level;
    if (code == CMD_MAX && !rep) nxt = LEVEL_MAX;
    if (code == CMD_MID && !rep) nxt = LEVEL_MID;
    if (code == CMD_OFF && !rep) nxt = LEVEL_MIN;
    if (code == CMD_UP) nxt = (level > LEVEL_MAX - LEVEL_STEP) ? LEVEL_MAX : level + LEVEL_STEP;
    if (code == CMD_DOWN) nxt = (level < LEVEL_STEP) ? LEVEL_MIN : level - LEVEL_STEP;
    if (nxt != level) exp_q.push_back({3{nxt}});
    level = nxt;
  endtask : expect_code

  task automatic settle();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    check(24'(exp_q.size()), 24'h0);
  endtask : settle

  task automatic frame(input logic [7:0] code);
    expect_code(code, 1'b0);
    last_code = code;
    i_ir_transmitter_model.send_data(CUSTOMER_CODE, code, ~code);
    settle();
  endtask : frame

  task automatic rep_frame();
    expect_code(last_code, 1'b1);
    i_ir_transmitter_model.send_repeat();
    settle();
  endtask : rep_frame

  // Bounded wait for halt or stop to rise
  task automatic wait_flag(input bit want_stop, input int unsigned limit);
    int n;
    n = 0;
    while ((want_stop ? stop_mode : halt_mode) !== 1'b1 && n < limit) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check({23'h0, want_stop ? stop_mode : halt_mode}, 24'h1);
    if (n >= limit) stop_test();
  endtask : wait_flag

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    bad_count = 0;
    checks_done = 0;
    level = LEVEL_MIN;
    last_code = CMD_OFF;
    last_led = 24'h0;
    void'($urandom(32'h0ECA));
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check(led_target, 24'h0);
    check({22'h0, halt_mode, stop_mode}, 24'h0);
    wait_flag(1'b1, 3000);
    frame(CMD_MAX);
    check({23'h0, stop_mode}, 24'h0);
    frame(CMD_UP);
    frame(CMD_DOWN);
    rep_frame();
    rep_frame();
    i_ir_transmitter_model.send_data(16'h3412, CMD_OFF, ~CMD_OFF);
    i_ir_transmitter_model.send_data(CUSTOMER_CODE, CMD_OFF, CMD_OFF);
    settle();
    frame(CMD_MID);
    rep_frame();
    wait_flag(1'b0, 3000);
    for (int i = 0; i < 2; i++) begin
      frame(8'($urandom_range(4, 0)));
      check({23'h0, halt_mode}, 24'h0);
    end
    frame(CMD_OFF);
    frame(CMD_DOWN);
    wait_flag(1'b1, 3000);
    stop_test();
  end
endmodule : tb
